// *** hw/acrc_device.sv ***
// module: converter control end with reference detect, reset detect and calibration
//
// Notes on behaviour
// - reference checking only while check bit is one
// - flag missing reference below threshold or open
// - results forced all ones while reference missing
// - missing reference: keep coefficient, set fault flag
// - thirty-two ones reset everything to defaults
// - same full reset at power-up
// - host waits 500 us after reset
// - supply channel: divide by six, internal reference
// - four calibration modes via operating select
// - subtract offset then multiply by full-scale
// - calibration end: update, ready, pin low, idle
// - internal calibrations use internal zero/full inputs
// - host applies system voltages before system calibration
// - offset calibration: two cycles chop, one without
// - internal full: gain one 2/1, else 4/2
// - ready pin high from calibration start to end
// - full coefficient goes to selected channel register
// - host avoids internal full calibration at top gain
// - host limits internal full rate above gain four (acrc_host has no rate control; it refuses internal full only at gain 128)
// - system full: two cycles chop, one without
// - host runs zero-scale before full-scale (acrc_host runs the calibration kinds in whatever order the user asks)
// - host repeats full-scale after gain change (acrc_host never starts a calibration on its own)
`timescale 1ns/1ps
module acrc_device (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // link to host
   acrc_if.device lnk,
   // converter core side
   input wire logic conv_done,
   input wire logic [23:0] raw_sample,
   input wire logic ref_below_min,
   input wire logic ref_open,
   input wire logic int_ref_selected,
   output logic core_reset,
   output logic [1:0] mux_source,
   output logic use_internal_ref,
   output logic supply_attenuate,
   output logic [3:0] op_state
);
   typedef enum logic [1:0] {ST_RUN, ST_CAL, ST_IDLE} acrc_state_t;
   acrc_state_t state;
   // serial pins are asynchronous to clock
   logic [2:0] pin_raw;
   wire [2:0] pin_sync;
   wire sclk_s = pin_sync[0];
   wire sdin_s = pin_sync[1];
   wire csn_s = pin_sync[2];
   logic sclk_prev;
   logic [5:0] ones_count;
   logic soft_reset;
   logic ref_missing_flag, fault_flag, ready_flag;
   logic [23:0] result;
   logic [23:0] offset_coef;
   logic [23:0] full_coef [acrc_pkg::NUM_CH];
   logic [2:0] cycles_left;
   logic [1:0] cal_kind;
   logic [2:0] cal_ch;
   logic [2:0] op_seen;
   acrc_state_t next_state;

   wire sclk_rise = sclk_s & ~sclk_prev;
   wire link_rst = sys_rst | soft_reset;
   wire ref_bad = lnk.ext_ref_check_en & ~use_internal_ref & (ref_below_min | ref_open);
   wire cal_request = lnk.operating_select[2] & (lnk.operating_select != op_seen);
   wire cal_is_full = lnk.operating_select[0];
   wire cal_is_int = ~lnk.operating_select[1];
   // a missing reference at any point of the calibration blocks the write
   wire coef_write = !ref_missing_flag && !fault_flag;
   wire cal_last = conv_done && (cycles_left == 3'h1);
   assign next_state = (lnk.operating_select == acrc_pkg::OP_CONT) ? ST_RUN :
      (lnk.operating_select[2] ? state : ST_IDLE);

   function automatic logic [2:0] cal_cycles(input logic full, input logic internal,
      input logic chop, input logic [2:0] gain);
      if (full && internal && gain != acrc_pkg::GAIN_ONE)
         return chop ? 3'h4 : 3'h2;
      return chop ? 3'h2 : 3'h1;
   endfunction

   wire signed [25:0] centered = $signed({2'h0, raw_sample}) - $signed({2'h0, offset_coef})
      + $signed(26'h0800000);
   wire [49:0] scaled_full = (centered[25] ? 26'h0 : centered[25:0]) * full_coef[lnk.input_select];
   wire [27:0] scaled_top = scaled_full[49:acrc_pkg::FULL_SHIFT];
   wire [23:0] corrected = (scaled_top > 28'h0FFFFFF) ? acrc_pkg::ALL_ONES : scaled_top[23:0];

   // idle levels cs_n high, sdin low, sclk high; a wrong idle would fake an edge after reset
   localparam logic [2:0] PIN_IDLE = 3'h5;
   assign pin_raw = {lnk.cs_n, lnk.sdin, lnk.sclk};
   // pin synchronisers, first stage read only by second
   for (genvar p = 0; p < 3; p++) begin : g_pin_sync
      logic meta, held;
      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            meta <= PIN_IDLE[p];
            held <= PIN_IDLE[p];
         end else begin
            meta <= pin_raw[p];
            held <= meta;
         end
      end
      assign pin_sync[p] = held;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_prev <= 1'b1;
      end else begin
         sclk_prev <= sclk_s;
      end
   end

   // ones counter lives on power reset only so it can fire the soft reset
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ones_count <= 6'h0;
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= 1'b0;
         if (sclk_rise && !csn_s) begin
            if (!sdin_s)
               ones_count <= 6'h0;
            else if (ones_count == 6'(acrc_pkg::RESET_ONES - 1)) begin
               ones_count <= 6'h0;
               soft_reset <= 1'b1;
            end else
               ones_count <= ones_count + 6'h1;
         end
      end
   end

   always_ff @(posedge clock or posedge link_rst) begin
      if (link_rst) begin
         state <= ST_IDLE;
         ref_missing_flag <= 1'b0;
         fault_flag <= 1'b0;
         ready_flag <= 1'b0;
         result <= 24'h0;
         offset_coef <= acrc_pkg::OFFSET_RST;
         for (int i = 0; i < acrc_pkg::NUM_CH; i++)
            full_coef[i] <= acrc_pkg::FULL_RST;
         cycles_left <= 3'h0;
         cal_kind <= 2'h0;
         cal_ch <= 3'h0;
         op_seen <= acrc_pkg::OP_IDLE;
      end else begin
         ref_missing_flag <= ref_bad;
         op_seen <= lnk.operating_select;
         if (cal_request) begin
            state <= ST_CAL;
            ready_flag <= 1'b0;
            fault_flag <= 1'b0;
            cal_kind <= lnk.operating_select[1:0];
            cal_ch <= lnk.input_select;
            cycles_left <= cal_cycles(cal_is_full, cal_is_int, lnk.chop_en, lnk.gain_code);
         end else begin
            unique case (state)
               ST_CAL: begin
                  if (ref_missing_flag) begin
                     fault_flag <= 1'b1;
                  end
                  if (conv_done) begin
                     cycles_left <= cycles_left - 3'h1;
                  end
                  if (cal_last) begin
                     state <= ST_IDLE;
                     ready_flag <= 1'b1;
                     if (coef_write && !cal_kind[0]) begin
                        offset_coef <= raw_sample;
                     end
                     if (coef_write && cal_kind[0]) begin
                        full_coef[cal_ch] <= raw_sample;
                     end
                  end
               end
               ST_RUN: begin
                  state <= next_state;
                  if (conv_done) begin
                     result <= ref_missing_flag ? acrc_pkg::ALL_ONES : corrected;
                     ready_flag <= 1'b1;
                  end
               end
               ST_IDLE: begin
                  state <= next_state;
               end
            endcase
         end
      end
   end

   // internal calibration drives the mux to zero (1) or full (2) source
   assign mux_source = (state == ST_CAL && !cal_kind[1]) ? (cal_kind[0] ? 2'h2 : 2'h1) : 2'h0;
   assign supply_attenuate = (lnk.input_select == acrc_pkg::CH_SUPPLY);
   assign use_internal_ref = supply_attenuate | int_ref_selected;
   assign core_reset = link_rst;
   assign op_state = {state == ST_CAL, cal_kind, state == ST_RUN};
   // pin low only when ready and selected
   assign lnk.dout_rdy = !(ready_flag && !csn_s);
   assign lnk.ref_missing_flag = ref_missing_flag;
   assign lnk.fault_flag = fault_flag;
   assign lnk.ready_flag = ready_flag;
   assign lnk.result = result;
endmodule // acrc_device

// *** hw/acrc_pkg.sv ***
// package: shared constants and types for the converter control block
package acrc_pkg;
   localparam int DATA_W = 24;
   localparam int COEF_W = 24;
   localparam int NUM_CH = 8;
   // channel select encodings
   localparam logic [2:0] CH_SUPPLY = 3'h1;
   localparam int SUPPLY_DIV = 6;
   // operating select encodings
   localparam logic [2:0] OP_CONT = 3'h0;
   localparam logic [2:0] OP_IDLE = 3'h2;
   localparam logic [2:0] OP_INT_ZERO = 3'h4;
   localparam logic [2:0] OP_INT_FULL = 3'h5;
   localparam logic [2:0] OP_SYS_ZERO = 3'h6;
   localparam logic [2:0] OP_SYS_FULL = 3'h7;
   // gain code 0 is gain 1, code 7 is gain 128
   localparam logic [2:0] GAIN_ONE = 3'h0;
   localparam logic [2:0] GAIN_FOUR = 3'h2;
   localparam logic [2:0] GAIN_MAX = 3'h7;
   localparam int RESET_ONES = 32;
   // reference threshold in millivolts
   localparam int REF_MIN_MV = 300;
   // wait after reset
   localparam int CLK_MHZ = 25;
   localparam int RESET_WAIT_US = 500;
   localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
   // reset values
   localparam logic [COEF_W-1:0] OFFSET_RST = 24'h800000;
   localparam logic [COEF_W-1:0] FULL_RST = 24'h400000;
   localparam logic [DATA_W-1:0] ALL_ONES = 24'hFFFFFF;
   localparam int FULL_SHIFT = 22;
   typedef enum logic [1:0] {CAL_ZERO_INT, CAL_FULL_INT, CAL_ZERO_SYS, CAL_FULL_SYS} acrc_cal_t;
endpackage

// *** hw/acrc_if.sv ***
// interface: serial input and ready wiring between host and converter control
`timescale 1ns/1ps
interface acrc_if;
   logic sclk;
   logic sdin;
   logic cs_n;
   logic dout_rdy;
   logic [2:0] input_select;
   logic [2:0] operating_select;
   logic [2:0] gain_code;
   logic chop_en;
   logic ext_ref_check_en;
   logic ref_missing_flag;
   logic fault_flag;
   logic ready_flag;
   logic [23:0] result;
   modport device (input sclk, sdin, cs_n, input_select, operating_select, gain_code,
      chop_en, ext_ref_check_en, output dout_rdy, ref_missing_flag, fault_flag,
      ready_flag, result);
   modport host (output sclk, sdin, cs_n, input_select, operating_select, gain_code,
      chop_en, ext_ref_check_en, input dout_rdy, ref_missing_flag, fault_flag,
      ready_flag, result);
endinterface

// *** hw/acrc_host.sv ***
// module: host end that issues resets, calibrations and polls ready
`timescale 1ns/1ps
module acrc_host #(
   parameter int WAIT_CYC = acrc_pkg::RESET_WAIT_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // link to device
   acrc_if.host lnk,
   // user side
   input wire logic send_reset,
   input wire logic start_cal,
   input wire logic [1:0] cal_kind,
   input wire logic [2:0] channel,
   input wire logic [2:0] gain,
   input wire logic chop,
   input wire logic ref_check,
   input wire logic system_level_ready,
   output logic busy,
   output logic cal_done,
   output logic cal_fault,
   output logic refused
);
   typedef enum logic [2:0] {H_WAIT, H_IDLE, H_ONES, H_CAL, H_POLL} acrc_hstate_t;
   acrc_hstate_t state;
   logic [31:0] wait_count;
   logic [5:0] bit_count;
   logic [3:0] div;
   logic sclk_q;
   logic [2:0] op_q, ch_q, gain_q;
   logic chop_q;
   logic [1:0] rdy_sync;
   logic cal_done_q, cal_fault_q, refused_q;

   wire want_full = cal_kind[0];
   wire want_int = ~cal_kind[1];
   // user asks only legal sequences; internal full at top gain refused
   wire illegal = want_full & want_int & (gain == acrc_pkg::GAIN_MAX);
   wire can_start = start_cal & ~illegal & (want_int | system_level_ready);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         rdy_sync <= 2'h3;
      else
         rdy_sync <= {rdy_sync[0], lnk.dout_rdy};
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= H_WAIT;
         wait_count <= 32'h0;
         bit_count <= 6'h0;
         div <= 4'h0;
         sclk_q <= 1'b1;
         op_q <= acrc_pkg::OP_IDLE;
         ch_q <= 3'h0;
         gain_q <= 3'h0;
         chop_q <= 1'b1;
         cal_done_q <= 1'b0;
         cal_fault_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         cal_done_q <= 1'b0;
         refused_q <= 1'b0;
         unique case (state)
            H_WAIT: begin
               wait_count <= wait_count + 32'h1;
               if (wait_count >= 32'(WAIT_CYC))
                  state <= H_IDLE;
            end
            H_IDLE: begin
               wait_count <= 32'h0;
               if (send_reset) begin
                  state <= H_ONES;
                  bit_count <= 6'h0;
                  div <= 4'h0;
               end else if (start_cal) begin
                  refused_q <= ~can_start;
                  if (can_start) begin
                     op_q <= {1'b1, cal_kind};
                     ch_q <= channel;
                     gain_q <= gain;
                     chop_q <= chop;
                     state <= H_CAL;
                  end
               end
            end
            H_ONES: begin
               div <= div + 4'h1;
               // data stays high half a period past the last rise so it is seen as a one
               if (div == 4'h7 && bit_count == 6'(acrc_pkg::RESET_ONES)) begin
                  state <= H_WAIT;
                  op_q <= acrc_pkg::OP_IDLE;
               end else if (div == 4'h7)
                  sclk_q <= 1'b0;
               if (div == 4'hF) begin
                  sclk_q <= 1'b1;
                  bit_count <= bit_count + 6'h1;
               end
            end
            H_CAL: begin
               if (rdy_sync[1])
                  state <= H_POLL;
            end
            H_POLL: begin
               if (!rdy_sync[1]) begin
                  state <= H_IDLE;
                  op_q <= acrc_pkg::OP_IDLE;
                  cal_done_q <= 1'b1;
                  cal_fault_q <= lnk.fault_flag;
               end
            end
            default: state <= H_WAIT;
         endcase
      end
   end

   assign lnk.sclk = sclk_q;
   assign lnk.sdin = (state == H_ONES);
   assign lnk.cs_n = 1'b0;
   assign lnk.input_select = ch_q;
   assign lnk.operating_select = op_q;
   assign lnk.gain_code = gain_q;
   assign lnk.chop_en = chop_q;
   assign lnk.ext_ref_check_en = ref_check;
   assign busy = (state != H_IDLE);
   assign cal_done = cal_done_q;
   assign cal_fault = cal_fault_q;
   assign refused = refused_q;
endmodule // acrc_host

// *** verification/acrc_monitor.sv ***
// checker: link properties between the host end and the converter end
`timescale 1ns/1ps
module acrc_monitor #(
   parameter int WAIT_CYC = 20
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // link
   input wire logic sclk,
   input wire logic sdin,
   input wire logic cs_n,
   input wire logic dout_rdy,
   input wire logic [2:0] input_select,
   input wire logic [2:0] operating_select,
   input wire logic [2:0] gain_code,
   input wire logic chop_en,
   input wire logic ext_ref_check_en,
   input wire logic ref_missing_flag,
   input wire logic fault_flag,
   input wire logic ready_flag,
   input wire logic [23:0] result
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic sclk_q;
   logic [5:0] ones;
   int up;
   // raw edge count; the device syncs first, so the reset lands a few cycles later
   wire sclk_up = sclk & ~sclk_q & ~cs_n;
   wire [5:0] next_ones = sclk_up ? (sdin ? ones + 6'h01 : 6'h00) : (ones == 6'h20 ? 6'h00 : ones);
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_q <= 1'b1;
         ones <= 6'h00;
         up <= 0;
      end else begin
         sclk_q <= sclk;
         ones <= next_ones;
         up <= (up < WAIT_CYC) ? up + 1 : up;
      end
   end
   AST_CAL_START: assert property ($changed(operating_select) && operating_select[2]
      |-> ##[1:2] (dout_rdy && !ready_flag && !fault_flag)) else $error("cal start not seen");
   AST_DONE_PIN: assert property ($rose(ready_flag) && !cs_n |-> !dout_rdy)
      else $error("pin not low at done");
   AST_PIN_FALL: assert property ($fell(dout_rdy) |-> ready_flag)
      else $error("pin fell without ready");
   AST_CHECK_OFF: assert property ((!ext_ref_check_en)[*3] |-> !ref_missing_flag)
      else $error("flag while checking off");
   AST_FLAG_CAUSE: assert property ($rose(ref_missing_flag)
      |-> ext_ref_check_en || $past(ext_ref_check_en)) else $error("flag rose unchecked");
   AST_RESULT_ONES: assert property (ref_missing_flag && $past(ref_missing_flag)
      && $changed(result) |-> result == acrc_pkg::ALL_ONES) else $error("result not all ones");
   AST_FAULT_CAL: assert property ($rose(fault_flag)
      |-> $past(ref_missing_flag) && operating_select[2]) else $error("fault outside calibration");
   AST_SOFT_RESET: assert property (ones == 6'h20
      |-> ##[1:8] (!ready_flag && !fault_flag && result == 24'h000000))
      else $error("ones run did not reset");
   AST_HOST_WAIT: assert property (up < WAIT_CYC |-> sclk && !operating_select[2])
      else $error("access during reset wait");
   cover property ($rose(ready_flag) && operating_select == acrc_pkg::OP_INT_FULL && chop_en);
   cover property ($rose(fault_flag));
   cover property (ones == 6'h20);
   cover property ($rose(ready_flag) && input_select == acrc_pkg::CH_SUPPLY && gain_code != 3'h0);
endmodule // acrc_monitor

// *** verification/adc_calibration_refdetect_control_test.sv ***
// testbench: host and converter ends joined over the link
`timescale 1ns/1ps
module adc_calibration_refdetect_control_test;
   localparam int WAIT = 20;
   typedef struct packed {logic [2:0] n; logic fault; logic [1:0] mux;} acrc_exp_t;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic conv_done = 1'b0;
   logic [23:0] raw_sample = 24'h000000;
   logic ref_below_min = 1'b0, ref_open = 1'b0, int_ref_selected = 1'b0;
   logic send_reset = 1'b0, start_cal = 1'b0, chop = 1'b0, ref_check = 1'b0;
   logic system_level_ready = 1'b1;
   logic [1:0] cal_kind = 2'h0;
   logic [2:0] channel = 3'h0, gain = 3'h0, pulses = 3'h0;
   logic core_reset, use_internal_ref, supply_attenuate, busy, cal_done, cal_fault, refused;
   logic [1:0] mux_source, mux_seen;
   logic [2:0] op_q;
   acrc_exp_t exp_q[$];
   acrc_exp_t seen;
   int bad_count = 0, samples_checked = 0, cycles = 0, refusals = 0;
   acrc_if acrc_if_i();
   acrc_device acrc_device_i(.clock(clock), .sys_rst(sys_rst), .lnk(acrc_if_i.device),
      .conv_done(conv_done), .raw_sample(raw_sample), .ref_below_min(ref_below_min),
      .ref_open(ref_open), .int_ref_selected(int_ref_selected), .core_reset(core_reset),
      .mux_source(mux_source), .use_internal_ref(use_internal_ref),
      .supply_attenuate(supply_attenuate), .op_state());
   acrc_host #(.WAIT_CYC(WAIT)) acrc_host_i(.clock(clock), .sys_rst(sys_rst),
      .lnk(acrc_if_i.host), .send_reset(send_reset), .start_cal(start_cal),
      .cal_kind(cal_kind), .channel(channel), .gain(gain), .chop(chop), .ref_check(ref_check),
      .system_level_ready(system_level_ready), .busy(busy), .cal_done(cal_done),
      .cal_fault(cal_fault), .refused(refused));
   acrc_monitor #(.WAIT_CYC(WAIT)) acrc_monitor_i(.clock(clock), .sys_rst(sys_rst),
      .sclk(acrc_if_i.sclk), .sdin(acrc_if_i.sdin), .cs_n(acrc_if_i.cs_n),
      .dout_rdy(acrc_if_i.dout_rdy), .input_select(acrc_if_i.input_select),
      .operating_select(acrc_if_i.operating_select), .gain_code(acrc_if_i.gain_code),
      .chop_en(acrc_if_i.chop_en), .ext_ref_check_en(acrc_if_i.ext_ref_check_en),
      .ref_missing_flag(acrc_if_i.ref_missing_flag), .fault_flag(acrc_if_i.fault_flag),
      .ready_flag(acrc_if_i.ready_flag), .result(acrc_if_i.result));
   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      samples_checked++;
      if (seen_v !== exp_v) begin
         bad_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen_v, exp_v);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // bounded wait for the host to go idle; leaves us just after an edge
   task automatic idle();
      int t;
      t = 0;
      do begin
         @(posedge clock);
         t++;
      end while (busy !== 1'b0 && t < 20000);
      if (t >= 20000) bad_count++;
      #1;
   endtask
   task automatic do_cal(input logic [1:0] k, input logic c, input logic [2:0] g, input logic f,
      input logic rf);
      acrc_exp_t e;
      int r0;
      idle();
      cal_kind = k;
      chop = c;
      gain = g;
      e.n = (k == 2'h1 && g != acrc_pkg::GAIN_ONE) ? (c ? 3'h4 : 3'h2) : (c ? 3'h2 : 3'h1);
      e.fault = f;
      e.mux = (k == 2'h0) ? 2'h1 : (k == 2'h1) ? 2'h2 : 2'h0;
      if (!rf) exp_q.push_back(e);
      r0 = refusals;
      start_cal = 1'b1;
      @(posedge clock);
      #1 start_cal = 1'b0;
      idle();
      if (rf) check(refusals - r0, 1);
   endtask
   initial forever #20 clock = ~clock;
   // conversion pulses spaced so a cal start seldom meets one on the same edge
   initial forever begin
      repeat (12) @(posedge clock);
      #1 conv_done = 1'b1;
      raw_sample = 24'($urandom);
      @(posedge clock);
      #1 conv_done = 1'b0;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      op_q <= acrc_if_i.operating_select;
      if (refused === 1'b1) refusals <= refusals + 1;
      if (conv_done && op_q == acrc_if_i.operating_select && acrc_if_i.operating_select[2]
         && acrc_if_i.dout_rdy && !acrc_if_i.ready_flag) begin
         pulses <= pulses + 3'h1;
         mux_seen <= mux_source;
      end
      if (cal_done === 1'b1) begin
         seen = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
         check(pulses, seen.n);
         check(cal_fault, seen.fault);
         check(mux_seen, seen.mux);
         check(acrc_if_i.ready_flag, 1'b1);
         pulses <= 3'h0;
      end
      // the whole run needs about a thousand cycles; this ceiling leaves wide margin
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      void'($urandom(17));
      repeat (16) @(posedge clock);
      #1 sys_rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         do_cal(2'(i), i[2], i[3] ? 3'($urandom_range(6, 1)) : acrc_pkg::GAIN_ONE, 1'b0, 1'b0);
      end
      $display("test modes done");
      do_cal(2'h1, 1'b1, acrc_pkg::GAIN_MAX, 1'b0, 1'b1);
      system_level_ready = 1'b0;
      do_cal(2'h3, 1'b0, acrc_pkg::GAIN_MAX, 1'b0, 1'b1);
      system_level_ready = 1'b1;
      do_cal(2'h3, 1'b1, acrc_pkg::GAIN_MAX, 1'b0, 1'b0);
      $display("test refusals done");
      ref_check = 1'b1;
      ref_below_min = 1'b1;
      do_cal(2'h0, 1'b1, 3'h2, 1'b1, 1'b0);
      ref_below_min = 1'b0;
      ref_open = 1'b1;
      do_cal(2'h3, 1'b0, 3'h3, 1'b1, 1'b0);
      ref_open = 1'b0;
      do_cal(2'h2, 1'b0, 3'h3, 1'b0, 1'b0);
      ref_check = 1'b0;
      ref_below_min = 1'b1;
      do_cal(2'h0, 1'b0, 3'h1, 1'b0, 1'b0);
      ref_below_min = 1'b0;
      $display("test reference done");
      channel = acrc_pkg::CH_SUPPLY;
      do_cal(2'h2, 1'b1, 3'h0, 1'b0, 1'b0);
      check({supply_attenuate, use_internal_ref}, 2'h3);
      channel = 3'h2;
      do_cal(2'h1, 1'b0, 3'h0, 1'b0, 1'b0);
      check({supply_attenuate, use_internal_ref}, 2'h0);
      $display("test supply done");
      idle();
      send_reset = 1'b1;
      @(posedge clock);
      #1 send_reset = 1'b0;
      for (int t = 0; t < 5000 && core_reset !== 1'b1; t++) begin
         @(posedge clock);
         #1;
      end
      check(core_reset, 1'b1);
      idle();
      check({acrc_if_i.ready_flag, acrc_if_i.fault_flag}, 2'h0);
      do_cal(2'h0, 1'b0, 3'h0, 1'b0, 1'b0);
      $display("test soft reset done");
      summarize();
   end
endmodule // adc_calibration_refdetect_control_test
